// ### eeprom_protect_pkg.sv
// Constants, types and register map for the EEPROM protection block
package eeprom_protect_pkg;

  // ==========================================================
  // Widths
  localparam int REG_ADDR_WIDTH = 8;
  localparam int EE_ADDR_WIDTH = 18;
  localparam int SIZE_WIDTH = 7;
  localparam int STATUS_WIDTH = 3;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [REG_ADDR_WIDTH-1:0] OFFSET_PROTECT_CONFIG = 8'h00;
  localparam logic [REG_ADDR_WIDTH-1:0] OFFSET_RESERVED_TWO = 8'h04;
  localparam logic [REG_ADDR_WIDTH-1:0] OFFSET_FLASH_STATUS = 8'h08;
  localparam logic [REG_ADDR_WIDTH-1:0] OFFSET_IRQ_MASK = 8'h0C;

  // ==========================================================
  // Field positions and reset values
  localparam int ENABLE_BIT = 7;
  localparam logic [4:0] STEP_LOW_ONES = 5'h1F;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] FAULT_CONFIG = 8'h7F;
  localparam logic [SIZE_WIDTH-1:0] FULL_SIZE_FIRST = 7'h5F;
  localparam logic [31:0] RESERVED_READ = 32'h0000_0000;
  localparam int VIOLATION_BIT = 0;
  localparam int BLOCK_REFUSED_BIT = 1;
  localparam int LOAD_FAULT_BIT = 2;
  localparam logic [STATUS_WIDTH-1:0] STATUS_RESET = 3'h0;
  localparam logic [STATUS_WIDTH-1:0] MASK_RESET = 3'h0;

  // ==========================================================
  // EEPROM window
  localparam logic [EE_ADDR_WIDTH-1:0] EE_BASE = 18'h00400;
  localparam logic [EE_ADDR_WIDTH-1:0] EE_END = 18'h00FFF;
  localparam logic [EE_ADDR_WIDTH-1:0] EE_STEP_LAST = 18'h0001F;

  // ==========================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    CMD_PROGRAM,
    CMD_SECTOR_ERASE,
    CMD_BLOCK_ERASE
  } cmd_kind_type;

  typedef struct packed {
    cmd_kind_type kind;
    logic [EE_ADDR_WIDTH-1:0] addr;
  } cmd_type;

  typedef struct packed {
    logic enable;
    logic [SIZE_WIDTH-1:0] size;
  } protect_config_type;

endpackage

// ### protect_range_check.sv
// Address range decision for the EEPROM protection window
module protect_range_check
  import eeprom_protect_pkg::*;
(
  // Active configuration
  input wire protect_config_type config_value,
  // Address under test
  input wire logic [EE_ADDR_WIDTH-1:0] addr,
  // Decisions
  output logic in_window,
  output logic in_range,
  output logic [EE_ADDR_WIDTH-1:0] top_addr
);

  logic [EE_ADDR_WIDTH-1:0] span;
  logic [EE_ADDR_WIDTH-1:0] raw_top;

  // ==========================================================
  // Range arithmetic
  always_comb
  begin
    // Size times 32 plus 31, starting at the base
    span = EE_ADDR_WIDTH'({config_value.size, STEP_LOW_ONES});
    raw_top = EE_BASE + span;
    // Large sizes run past the array and cover it whole
    top_addr = (raw_top > EE_END) ? EE_END : raw_top;
    in_window = (addr >= EE_BASE) && (addr <= EE_END);
    in_range = config_value.enable && (addr >= EE_BASE) && (addr <= top_addr);
  end

endmodule

// ### eeprom_protection_control.sv
// EEPROM protection register, range check and AXI4-Lite register slave
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
module eeprom_protection_control
  import eeprom_protect_pkg::*;
(
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [REG_ADDR_WIDTH-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [REG_ADDR_WIDTH-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Protection byte load from the reset sequencer
  input wire logic load_valid,
  input wire logic [7:0] load_byte,
  input wire logic load_double_fault,
  // Program and erase requests from the command engine
  input wire logic cmd_valid,
  input wire cmd_type cmd,
  output logic cmd_done,
  output logic cmd_refused,
  // Interrupt
  output logic irq
);

  protect_config_type eeprom_protect_config;
  logic [STATUS_WIDTH-1:0] flash_status_reg;
  logic [STATUS_WIDTH-1:0] next_status;
  logic [STATUS_WIDTH-1:0] irq_mask;
  logic [STATUS_WIDTH-1:0] events;
  logic aw_held;
  logic w_held;
  logic [REG_ADDR_WIDTH-1:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_lane0;
  logic [REG_ADDR_WIDTH-1:0] rd_addr;
  logic do_write;
  logic rd_take;
  logic status_read;
  logic [31:0] read_word;
  logic read_hit;
  logic write_hit;
  logic cmd_take;
  logic in_window;
  logic in_range;
  logic [EE_ADDR_WIDTH-1:0] top_addr;
  logic refuse_now;

  // ==========================================================
  // Range check
  protect_range_check range_check (
    .config_value(eeprom_protect_config),
    .addr(cmd.addr),
    .in_window(in_window),
    .in_range(in_range),
    .top_addr(top_addr)
  );

  // ==========================================================
  // Command decision
  assign cmd_take = ce && cmd_valid;

  always_comb
  begin
    // Any enabled range starts at the base, so one sector is always covered
    if (cmd.kind == CMD_BLOCK_ERASE)
      refuse_now = eeprom_protect_config.enable;
    else
      refuse_now = in_range;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmd_done <= 1'b0;
      cmd_refused <= 1'b0;
    end
    else if (ce)
    begin
      cmd_done <= cmd_valid && !refuse_now;
      cmd_refused <= cmd_valid && refuse_now;
    end
  end

  // ==========================================================
  // Protection register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      eeprom_protect_config <= CONFIG_RESET;
    else if (ce)
    begin
      if (load_valid)
      begin
        if (load_double_fault)
          eeprom_protect_config <= FAULT_CONFIG;
        else
          eeprom_protect_config <= load_byte;
      end
      else if (write_hit && wr_addr == OFFSET_PROTECT_CONFIG && wr_lane0)
        eeprom_protect_config <= wr_data;
    end
  end

  // ==========================================================
  // Status, mask and interrupt
  always_comb
  begin
    events = '0;
    events[VIOLATION_BIT] = cmd_take && refuse_now;
    events[BLOCK_REFUSED_BIT] = cmd_take && refuse_now && cmd.kind == CMD_BLOCK_ERASE;
    events[LOAD_FAULT_BIT] = ce && load_valid && load_double_fault;
    next_status = status_read ? STATUS_RESET : flash_status_reg;
    // An event in the clearing cycle survives the read
    next_status = next_status | events;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flash_status_reg <= STATUS_RESET;
      irq <= 1'b0;
    end
    else if (ce)
    begin
      flash_status_reg <= next_status;
      irq <= |(next_status & irq_mask);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_mask <= MASK_RESET;
    else if (ce && write_hit && wr_addr == OFFSET_IRQ_MASK && wr_lane0)
      irq_mask <= wr_data[STATUS_WIDTH-1:0];
  end

  // ==========================================================
  // AXI4-Lite write path
  assign do_write = ce && aw_held && w_held && !bvalid;
  assign write_hit = do_write;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        awready <= 1'b0;
        aw_held <= 1'b1;
        wr_addr <= {awaddr[REG_ADDR_WIDTH-1:2], 2'b00};
      end
      if (wvalid && wready)
      begin
        wready <= 1'b0;
        w_held <= 1'b1;
        wr_data <= wdata[7:0];
        wr_lane0 <= wstrb[0];
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        // Reserved register takes the write silently
        unique case (wr_addr)
          OFFSET_PROTECT_CONFIG, OFFSET_RESERVED_TWO, OFFSET_FLASH_STATUS,
          OFFSET_IRQ_MASK: bresp <= RESP_OKAY;
          default: bresp <= RESP_SLVERR;
        endcase
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  assign rd_take = ce && arvalid && arready;
  assign status_read = rd_take && {araddr[REG_ADDR_WIDTH-1:2], 2'b00} == OFFSET_FLASH_STATUS;

  always_comb
  begin
    read_word = '0;
    read_hit = 1'b1;
    unique case ({araddr[REG_ADDR_WIDTH-1:2], 2'b00})
      OFFSET_PROTECT_CONFIG: read_word = {24'h00_0000, eeprom_protect_config};
      OFFSET_RESERVED_TWO: read_word = RESERVED_READ;
      OFFSET_FLASH_STATUS: read_word = {29'h0000_0000, flash_status_reg};
      OFFSET_IRQ_MASK: read_word = {29'h0000_0000, irq_mask};
      default: read_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
      rd_addr <= '0;
    end
    else if (ce)
    begin
      if (rd_take)
      begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= read_word;
        rresp <= read_hit ? RESP_OKAY : RESP_SLVERR;
        rd_addr <= {araddr[REG_ADDR_WIDTH-1:2], 2'b00};
      end
      else if (rvalid && rready)
      begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Checks
  reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && rd_addr == OFFSET_RESERVED_TWO |-> rdata == RESERVED_READ && rresp == RESP_OKAY)
    else $error("reserved register read nonzero");

  reserved_nowrite_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && wr_addr == OFFSET_RESERVED_TWO && !load_valid
    |=> $stable(eeprom_protect_config) && $stable(irq_mask))
    else $error("reserved write changed state");

  fault_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && load_valid && load_double_fault
    |=> eeprom_protect_config == FAULT_CONFIG && flash_status_reg[LOAD_FAULT_BIT])
    else $error("double fault load not forced");

  violation_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_take && cmd.kind != CMD_BLOCK_ERASE && eeprom_protect_config.enable
    && cmd.addr >= EE_BASE && cmd.addr <= top_addr
    |=> cmd_refused && !cmd_done && flash_status_reg[VIOLATION_BIT])
    else $error("protected write not refused");

  block_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_take && cmd.kind == CMD_BLOCK_ERASE && eeprom_protect_config.enable
    |=> cmd_refused ##0 flash_status_reg[BLOCK_REFUSED_BIT])
    else $error("block erase not refused");

  disabled_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_take && !eeprom_protect_config.enable |=> cmd_done && !cmd_refused)
    else $error("disabled protection refused a command");

  step_size_a: assert property (@(posedge aclk) disable iff (!aresetn)
    eeprom_protect_config.size < FULL_SIZE_FIRST
    |-> top_addr - EE_BASE == EE_ADDR_WIDTH'({eeprom_protect_config.size, STEP_LOW_ONES}))
    else $error("protected span not in 32-byte steps");

  zero_size_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_take && cmd.kind == CMD_PROGRAM && eeprom_protect_config == 8'h80
    && cmd.addr == EE_BASE + EE_STEP_LAST ##1 cmd_take && cmd.kind == CMD_PROGRAM
    && eeprom_protect_config == 8'h80 && cmd.addr == EE_BASE + EE_STEP_LAST + 18'h00001
    |-> cmd_refused ##1 cmd_done)
    else $error("zero size range wrong");

  full_size_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_take && eeprom_protect_config.enable
    && eeprom_protect_config.size >= FULL_SIZE_FIRST && in_window |=> cmd_refused)
    else $error("full size left a hole");

  range_top_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_take && cmd.kind != CMD_BLOCK_ERASE && in_window && cmd.addr > top_addr
    |=> cmd_done)
    else $error("address above range refused");

endmodule

// ### tb_top.sv
// Self-checking testbench for the EEPROM protection block
module tb_top
  import eeprom_protect_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic awvalid = 1'b0;
  logic awready;
  logic [REG_ADDR_WIDTH-1:0] awaddr = 8'h00;
  logic wvalid = 1'b0;
  logic wready;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic bvalid;
  logic bready = 1'b0;
  logic [1:0] bresp;
  logic arvalid = 1'b0;
  logic arready;
  logic [REG_ADDR_WIDTH-1:0] araddr = 8'h00;
  logic rvalid;
  logic rready = 1'b0;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic load_valid = 1'b0;
  logic [7:0] load_byte = 8'h00;
  logic load_double_fault = 1'b0;
  logic cmd_valid = 1'b0;
  cmd_type cmd = '0;
  logic cmd_done;
  logic cmd_refused;
  logic irq;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [3:0] strb = 4'hF;

  eeprom_protection_control uut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .load_valid(load_valid), .load_byte(load_byte), .load_double_fault(load_double_fault),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_done(cmd_done), .cmd_refused(cmd_refused),
    .irq(irq)
  );

  initial
  begin
    forever #5 aclk = ~aclk;
  end

  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Both channels offered together and each released once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_left;
    logic w_left;
    aw_left = 1'b1;
    w_left = 1'b1;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= strb;
    bready <= 1'b1;
    while (aw_left || w_left)
    begin
      @(posedge aclk);
      if (aw_left && awready === 1'b1)
      begin
        aw_left = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_left && wready === 1'b1)
      begin
        w_left = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, rsp);
    check({30'h0, rsp}, {30'h0, RESP_OKAY});
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a, rd, rsp);
    check(rd, exp);
  endtask

  // One request; answer pulse looked at in the cycle after the take
  task automatic cmd_check(input cmd_kind_type k, input logic [17:0] a, input logic refuse);
    @(posedge aclk);
    cmd_valid <= 1'b1;
    cmd <= '{kind: k, addr: a};
    @(posedge aclk);
    cmd_valid <= 1'b0;
    #1;
    check({30'h0, cmd_refused, cmd_done}, {30'h0, refuse, ~refuse});
  endtask

  task automatic load(input logic [7:0] b, input logic fault);
    @(posedge aclk);
    load_valid <= 1'b1;
    load_byte <= b;
    load_double_fault <= fault;
    @(posedge aclk);
    load_valid <= 1'b0;
  endtask

  // ==========================================================
  // Tests
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd_check(OFFSET_PROTECT_CONFIG, 32'h0000_0000);
    rd_check(OFFSET_FLASH_STATUS, 32'h0000_0000);
    rd_check(OFFSET_IRQ_MASK, 32'h0000_0000);
    $display("test reset_values done");
    wr(OFFSET_RESERVED_TWO, 32'hFFFF_FFFF);
    rd_check(OFFSET_RESERVED_TWO, 32'h0000_0000);
    axi_read(8'h10, rd, rsp);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR});
    axi_write(8'h10, 32'h0000_0000, rsp);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR});
    // Low byte lane off: the register must keep its value
    strb = 4'hE;
    wr(OFFSET_IRQ_MASK, 32'h0000_0007);
    strb = 4'hF;
    rd_check(OFFSET_IRQ_MASK, 32'h0000_0000);
    $display("test reserved_and_unmapped done");
    wr(OFFSET_PROTECT_CONFIG, 32'h0000_0005);
    cmd_check(CMD_PROGRAM, 18'h00400, 1'b0);
    cmd_check(CMD_BLOCK_ERASE, 18'h00400, 1'b0);
    wr(OFFSET_PROTECT_CONFIG, 32'h0000_0080);
    rd_check(OFFSET_PROTECT_CONFIG, 32'h0000_0080);
    cmd_check(CMD_PROGRAM, 18'h003FF, 1'b0);
    cmd_check(CMD_PROGRAM, 18'h00400, 1'b1);
    cmd_check(CMD_SECTOR_ERASE, 18'h0041F, 1'b1);
    cmd_check(CMD_PROGRAM, 18'h00420, 1'b0);
    // Back to back: last protected byte, then the first free one
    @(posedge aclk);
    cmd_valid <= 1'b1;
    cmd <= '{kind: CMD_PROGRAM, addr: 18'h0041F};
    @(posedge aclk);
    cmd <= '{kind: CMD_PROGRAM, addr: 18'h00420};
    #1;
    check({30'h0, cmd_refused, cmd_done}, 32'h0000_0002);
    @(posedge aclk);
    cmd_valid <= 1'b0;
    #1;
    check({30'h0, cmd_refused, cmd_done}, 32'h0000_0001);
    wr(OFFSET_PROTECT_CONFIG, 32'h0000_0085);
    cmd_check(CMD_SECTOR_ERASE, 18'h004BF, 1'b1);
    cmd_check(CMD_SECTOR_ERASE, 18'h004C0, 1'b0);
    wr(OFFSET_PROTECT_CONFIG, 32'h0000_00DF);
    cmd_check(CMD_PROGRAM, 18'h00FFF, 1'b1);
    cmd_check(CMD_PROGRAM, 18'h01000, 1'b0);
    wr(OFFSET_PROTECT_CONFIG, 32'h0000_00FF);
    cmd_check(CMD_PROGRAM, 18'h00FFF, 1'b1);
    $display("test range_sizes done");
    rd_check(OFFSET_FLASH_STATUS, 32'h0000_0001);
    rd_check(OFFSET_FLASH_STATUS, 32'h0000_0000);
    wr(OFFSET_IRQ_MASK, 32'h0000_0007);
    cmd_check(CMD_BLOCK_ERASE, 18'h00FFF, 1'b1);
    check({31'h0, irq}, 32'h0000_0001);
    rd_check(OFFSET_FLASH_STATUS, 32'h0000_0003);
    @(posedge aclk);
    #1;
    check({31'h0, irq}, 32'h0000_0000);
    $display("test violation_irq done");
    // A faulty load must not leave the old value in place
    load(8'h12, 1'b1);
    rd_check(OFFSET_PROTECT_CONFIG, {24'h0, FAULT_CONFIG});
    rd_check(OFFSET_FLASH_STATUS, 32'h0000_0004);
    // Reset clears the register; the reprogrammed byte takes effect on the load that follows
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_check(OFFSET_PROTECT_CONFIG, 32'h0000_0000);
    rd_check(OFFSET_FLASH_STATUS, 32'h0000_0000);
    load(8'h83, 1'b0);
    rd_check(OFFSET_PROTECT_CONFIG, 32'h0000_0083);
    $display("test reset_reload done");
    // Clock enable low: a request must be ignored
    @(posedge aclk);
    ce <= 1'b0;
    cmd_valid <= 1'b1;
    cmd <= '{kind: CMD_BLOCK_ERASE, addr: 18'h00400};
    @(posedge aclk);
    ce <= 1'b1;
    cmd_valid <= 1'b0;
    #1;
    check({30'h0, cmd_refused, cmd_done}, 32'h0000_0000);
    rd_check(OFFSET_FLASH_STATUS, 32'h0000_0000);
    $display("test clock_enable done");
    cmd_check(CMD_PROGRAM, 18'h0047F, 1'b1);
    cmd_check(CMD_PROGRAM, 18'h00480, 1'b0);
    $display("test load_port done");
    close_out();
  end

  // Tests need under 150 cycles; this is far beyond
  initial
  begin
    #200000;
    n_mismatch++;
    close_out();
  end
endmodule
